// [include/edge_detect_if.sv]
// Pin, edge mode and detected event between top and edge detector
`timescale 1ns/1ps
`default_nettype none
interface edge_detect_if;
    import intc_pkg::*;
    logic pin;
    edge_mode_e mode;
    logic hit;
    modport det (input pin, input mode, output hit);
    modport user (output pin, output mode, input hit);
endinterface
`default_nettype wire

// [include/intc_pkg.sv]
// Shared constants and types for the prioritised interrupt logic
// How it works
// RQ1 - External pins trigger on falling, rising, both edges
// RQ2 - External flags auto-clear when their vector is taken
// RQ3 - Timer match sets its timer request flag
// RQ4 - Finished conversion sets the converter flag
// RQ5 - Watchdog match flags only when reset-select is 0
// RQ6 - Interval counter overflow sets interval flag
// RQ7 - Master, enable and flag gate each maskable source
// RQ8 - Disabled source is never accepted
// RQ9 - Clear master enable blocks all maskable sources
// RQ10 - Fixed priority from pin a down to interval
// RQ11 - Each source has its own fixed vector address
// RQ12 - Acceptance clears master, pushes return and status
// RQ13 - Software clears flag before enabling master again
// RQ14 - Software reads and writes every request flag
// RQ15 - Flag held until taken; acceptance takes eight periods
// RQ16 - Edge-select setting picks each pin's active edge
// RQ17 - Simultaneous requests resolved by higher priority first
// RQ18 - Acceptance clears taken flag, three stack pushes
// RQ19 - One request out with winning source's vector
package intc_pkg;
    localparam int NUM_SRC = 7;
    // Source index equals priority order, 0 is highest
    localparam int SRC_EXT_A = 0;
    localparam int SRC_EXT_B = 1;
    localparam int SRC_TIMER_A = 2;
    localparam int SRC_TIMER_B = 3;
    localparam int SRC_CONV = 4;
    localparam int SRC_WDOG = 5;
    localparam int SRC_INTERVAL = 6;
    // Master enable position in the status word
    localparam int MASTER_EN_BIT = 2;
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_EXT_A = 16'hfffa;
    localparam logic [15:0] VEC_EXT_B = 16'hfff8;
    localparam logic [15:0] VEC_TIMER_A = 16'hfff6;
    localparam logic [15:0] VEC_TIMER_B = 16'hfff4;
    localparam logic [15:0] VEC_CONV = 16'hffec;
    localparam logic [15:0] VEC_WDOG = 16'hffea;
    localparam logic [15:0] VEC_INTERVAL = 16'hffe8;
    localparam logic [6:0] FLAGS_RESET = 7'h00;
    // One oscillator period is one clock here
    localparam int ACCEPT_OSC_PERIODS = 8;
    localparam int CLOCKS_PER_OSC = 1;
    localparam int ACCEPT_CYCLES = ACCEPT_OSC_PERIODS * CLOCKS_PER_OSC;
    localparam logic [2:0] ACCEPT_LAST = 3'(ACCEPT_CYCLES - 1);
    localparam logic [2:0] PUSH_FIRST = 3'h1;
    localparam logic [2:0] PUSH_LAST = 3'h3;
    typedef enum logic [1:0] {EDGE_OFF, EDGE_FALL, EDGE_RISE, EDGE_BOTH} edge_mode_e;
    typedef enum logic {ST_IDLE, ST_ACCEPT} accept_state_e;

    function automatic logic [15:0] vector_of(input logic [2:0] src);
        logic [15:0] v;
        v = VEC_INTERVAL;
        unique case (src)
            3'h0: v = VEC_EXT_A;
            3'h1: v = VEC_EXT_B;
            3'h2: v = VEC_TIMER_A;
            3'h3: v = VEC_TIMER_B;
            3'h4: v = VEC_CONV;
            3'h5: v = VEC_WDOG;
            default: v = VEC_INTERVAL;
        endcase
        return v;
    endfunction
endpackage

// [rtl/ext_edge_detect.sv]
// Edge detector for one external interrupt pin
`timescale 1ns/1ps
`default_nettype none
module ext_edge_detect
    import intc_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    edge_detect_if.det ed
);
    logic prev_ff;
    logic primed_ff;
    logic rise;
    logic fall;

    // First sample after reset is not an edge
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            prev_ff <= 1'b0;
            primed_ff <= 1'b0;
        end
        else
        begin
            prev_ff <= ed.pin;
            primed_ff <= 1'b1;
        end
    end

    assign rise = primed_ff && !prev_ff && ed.pin;
    assign fall = primed_ff && prev_ff && !ed.pin;
    // RQ1 edge mode select
    assign ed.hit = (rise && (ed.mode == EDGE_RISE || ed.mode == EDGE_BOTH))
        || (fall && (ed.mode == EDGE_FALL || ed.mode == EDGE_BOTH));

    property p_fall_only;
        @(posedge clock_i) disable iff (reset_i)
        (ed.mode == EDGE_FALL) && rise |-> !ed.hit;
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("rising edge hit in falling mode"); // RQ1
endmodule
`default_nettype wire

// [rtl/prioritized_interrupt_logic.sv]
// Interrupt flags, masking, priority and acceptance sequencer
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_logic
    import intc_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ext_irq_pin_a_i,
    input wire logic ext_irq_pin_b_i,
    input wire logic [3:0] edge_select_reg_i,
    input wire logic timer_a_match_i,
    input wire logic timer_b_match_i,
    input wire logic conv_done_i,
    input wire logic watchdog_match_i,
    input wire logic watchdog_reset_select_i,
    input wire logic interval_overflow_i,
    input wire logic [6:0] enable_flags_i,
    input wire logic [7:0] status_word_i,
    input wire logic [15:0] return_pc_i,
    input wire logic instr_done_i,
    input wire logic flags_wr_i,
    input wire logic [6:0] flags_wr_data_i,
    output logic [6:0] request_flags_o,
    output logic irq_req_o,
    output logic [15:0] irq_vector_o,
    output logic accepting_o,
    output logic master_enable_clr_o,
    output logic stack_push_o,
    output logic [7:0] stack_data_o,
    output logic pc_load_o,
    output logic [15:0] pc_vector_o
);
    logic [6:0] flags_ff;
    logic [6:0] nxt_flags;
    logic [6:0] set_vec;
    logic [6:0] armed;
    logic [2:0] win_idx;
    logic any_armed;
    logic master_en;
    logic start;
    accept_state_e state_ff;
    logic [2:0] step_ff;
    logic [2:0] src_ff;
    logic [15:0] ret_pc_ff;
    logic [7:0] psw_ff;
    logic clr_ff;
    logic push_ff;
    logic load_ff;
    logic [7:0] push_data_ff;
    logic [15:0] pc_vec_ff;

    edge_detect_if pin_a_if ();
    edge_detect_if pin_b_if ();

    // RQ16 edge select fields
    assign pin_a_if.pin = ext_irq_pin_a_i;
    assign pin_a_if.mode = edge_mode_e'(edge_select_reg_i[1:0]);
    assign pin_b_if.pin = ext_irq_pin_b_i;
    assign pin_b_if.mode = edge_mode_e'(edge_select_reg_i[3:2]);

    ext_edge_detect u_edge_a (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ed(pin_a_if)
    );

    ext_edge_detect u_edge_b (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ed(pin_b_if)
    );

    always_comb
    begin
        set_vec = '0;
        // RQ1 pin events
        set_vec[SRC_EXT_A] = pin_a_if.hit;
        set_vec[SRC_EXT_B] = pin_b_if.hit;
        // RQ3 timer matches
        set_vec[SRC_TIMER_A] = timer_a_match_i;
        set_vec[SRC_TIMER_B] = timer_b_match_i;
        // RQ4 conversion done
        set_vec[SRC_CONV] = conv_done_i;
        // RQ5 watchdog as interrupt only
        set_vec[SRC_WDOG] = watchdog_match_i && !watchdog_reset_select_i;
        // RQ6 interval overflow
        set_vec[SRC_INTERVAL] = interval_overflow_i;
    end

    always_comb
    begin
        nxt_flags = flags_ff;
        // RQ14 software write
        if (flags_wr_i)
        begin
            nxt_flags = flags_wr_data_i;
        end
        // RQ18 taken flag cleared, also RQ2 for pins
        if (clr_ff)
        begin
            nxt_flags[src_ff] = 1'b0;
        end
        // RQ15 held until cleared; new events win
        nxt_flags = nxt_flags | set_vec;
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            flags_ff <= FLAGS_RESET;
        end
        else
        begin
            flags_ff <= nxt_flags;
        end
    end

    assign master_en = status_word_i[MASTER_EN_BIT];
    // RQ7 RQ8 RQ9 three-way gating
    assign armed = master_en ? (flags_ff & enable_flags_i) : 7'h00;
    assign any_armed = |armed;

    // RQ10 RQ17 lowest index wins
    always_comb
    begin
        win_idx = 3'(SRC_INTERVAL);
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (armed[i])
            begin
                win_idx = 3'(i);
            end
        end
    end

    // RQ19 single request with vector; RQ11 table
    assign irq_req_o = any_armed && (state_ff == ST_IDLE);
    assign irq_vector_o = vector_of(win_idx);
    assign request_flags_o = flags_ff;
    assign start = irq_req_o && instr_done_i;
    assign accepting_o = (state_ff == ST_ACCEPT);

    // RQ15 acceptance window after instruction end
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state_ff <= ST_IDLE;
            step_ff <= 3'h0;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                begin
                    step_ff <= 3'h0;
                    if (start)
                    begin
                        state_ff <= ST_ACCEPT;
                    end
                end
                ST_ACCEPT:
                begin
                    step_ff <= step_ff + 3'h1;
                    if (step_ff == ACCEPT_LAST)
                    begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Snapshot so a change in the core cannot tear the frame
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            src_ff <= 3'h0;
            ret_pc_ff <= 16'h0000;
            psw_ff <= 8'h00;
        end
        else if (start)
        begin
            src_ff <= win_idx;
            ret_pc_ff <= return_pc_i;
            psw_ff <= status_word_i;
        end
    end

    // RQ12 clear master, push, load vector
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            clr_ff <= 1'b0;
            push_ff <= 1'b0;
            load_ff <= 1'b0;
            push_data_ff <= 8'h00;
            pc_vec_ff <= VEC_RESET;
        end
        else
        begin
            clr_ff <= start;
            // RQ18 three pushes, one stack step each
            push_ff <= accepting_o && (step_ff < PUSH_LAST);
            unique case (step_ff)
                3'h0: push_data_ff <= ret_pc_ff[15:8];
                3'h1: push_data_ff <= ret_pc_ff[7:0];
                default: push_data_ff <= psw_ff;
            endcase
            load_ff <= accepting_o && (step_ff == ACCEPT_LAST - 3'h1);
            if (accepting_o && step_ff == ACCEPT_LAST - 3'h1)
            begin
                pc_vec_ff <= vector_of(src_ff);
            end
        end
    end

    assign master_enable_clr_o = clr_ff;
    assign stack_push_o = push_ff;
    assign stack_data_o = push_data_ff;
    assign pc_load_o = load_ff;
    assign pc_vector_o = pc_vec_ff;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    sequence s_start;
        state_ff == ST_IDLE && irq_req_o && instr_done_i;
    endsequence
    sequence s_pushes;
        stack_push_o [*3];
    endsequence
    property p_accept_seq;
        s_start |=> master_enable_clr_o ##1 s_pushes ##4 pc_load_o;
    endproperty
    a_accept_seq: assert property (p_accept_seq) else $error("acceptance timing wrong"); // RQ12
    property p_gate;
        irq_req_o |-> master_en && |(flags_ff & enable_flags_i);
    endproperty
    a_gate: assert property (p_gate) else $error("request without gating"); // RQ7
    property p_master_off;
        !master_en |-> !irq_req_o;
    endproperty
    a_master_off: assert property (p_master_off) else $error("request with master off"); // RQ9
    property p_disabled;
        (flags_ff & enable_flags_i) == 7'h00 |-> !irq_req_o;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled source requested"); // RQ8
    property p_timer_set;
        timer_a_match_i |=> flags_ff[SRC_TIMER_A];
    endproperty
    a_timer_set: assert property (p_timer_set) else $error("timer flag not set"); // RQ3
    property p_conv_set;
        conv_done_i |=> flags_ff[SRC_CONV];
    endproperty
    a_conv_set: assert property (p_conv_set) else $error("converter flag not set"); // RQ4
    property p_wdog_reset;
        watchdog_match_i && watchdog_reset_select_i && !flags_ff[SRC_WDOG] && !flags_wr_i
            |=> !flags_ff[SRC_WDOG];
    endproperty
    a_wdog_reset: assert property (p_wdog_reset) else $error("watchdog flag in reset mode"); // RQ5
    property p_interval;
        interval_overflow_i |=> flags_ff[SRC_INTERVAL];
    endproperty
    a_interval: assert property (p_interval) else $error("interval flag not set"); // RQ6
    property p_prio;
        armed[SRC_EXT_A] |-> irq_vector_o == VEC_EXT_A;
    endproperty
    a_prio: assert property (p_prio) else $error("top priority vector wrong"); // RQ10
    property p_clear_taken;
        master_enable_clr_o && !set_vec[src_ff] && !flags_wr_i |=> !flags_ff[src_ff];
    endproperty
    a_clear_taken: assert property (p_clear_taken) else $error("taken flag not cleared"); // RQ18
endmodule
`default_nettype wire

// [verification/core_model.sv]
// Behavioural core owning the status word and the stack
`timescale 1ns/1ps
`default_nettype none
module core_model
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ie_set_i,
    input wire logic ie_clr_i,
    input wire logic master_enable_clr_i,
    input wire logic stack_push_i,
    input wire logic [7:0] stack_data_i,
    output logic [7:0] status_word_o,
    output logic [2:0] push_count_o,
    output logic [23:0] stack_o
);
    always_ff @(posedge clock_i)
    begin
        if (reset_i || ie_clr_i)
            status_word_o <= 8'h60;
        else if (master_enable_clr_i)
            status_word_o[2] <= 1'b0;
        else if (ie_set_i)
            status_word_o <= 8'h64;
    end
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            push_count_o <= 3'h0;
        else if (stack_push_i)
            push_count_o <= push_count_o + 3'h1;
    end
    always_ff @(posedge clock_i)
    begin
        if (stack_push_i)
            stack_o <= {stack_o[15:0], stack_data_i};
    end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the interrupt logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import intc_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic pin_a = 1'b1, pin_b = 1'b1, wdsel = 1'b0, idone = 1'b0, fwr = 1'b0;
    logic ie_set = 1'b0, ie_clr = 1'b0;
    logic [6:0] ev = 7'h00, en = 7'h00, fdata = 7'h00;
    logic [3:0] esel = 4'h0;
    logic [6:0] flags;
    logic irq, acc, mclr, push, pcl;
    logic [15:0] vec, pcv;
    logic [7:0] sdata, status_word;
    logic [2:0] pcount;
    logic [23:0] stk;
    logic [15:0] vt [7] = '{VEC_EXT_A, VEC_EXT_B, VEC_TIMER_A, VEC_TIMER_B,
                            VEC_CONV, VEC_WDOG, VEC_INTERVAL};
    int failures = 0;
    int comparisons = 0;

    always #4 clock_i = ~clock_i;

    prioritized_interrupt_logic DUT (.clock_i(clock_i), .reset_i(reset_i),
        .ext_irq_pin_a_i(pin_a), .ext_irq_pin_b_i(pin_b), .edge_select_reg_i(esel),
        .timer_a_match_i(ev[2]), .timer_b_match_i(ev[3]), .conv_done_i(ev[4]),
        .watchdog_match_i(ev[5]), .watchdog_reset_select_i(wdsel),
        .interval_overflow_i(ev[6]), .enable_flags_i(en), .status_word_i(status_word),
        .return_pc_i(16'h1234), .instr_done_i(idone), .flags_wr_i(fwr),
        .flags_wr_data_i(fdata), .request_flags_o(flags), .irq_req_o(irq),
        .irq_vector_o(vec), .accepting_o(acc), .master_enable_clr_o(mclr),
        .stack_push_o(push), .stack_data_o(sdata), .pc_load_o(pcl), .pc_vector_o(pcv));

    core_model core (.clock_i(clock_i), .reset_i(reset_i), .ie_set_i(ie_set),
        .ie_clr_i(ie_clr), .master_enable_clr_i(mclr), .stack_push_i(push),
        .stack_data_i(sdata), .status_word_o(status_word), .push_count_o(pcount), .stack_o(stk));

    task automatic step(input int n = 1);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
            $display("BAD %0t got %h expected %h", $time, got, exp);
        if (got !== exp)
            failures++;
    endtask

    task automatic wr_flags(input logic [6:0] d);
        fwr = 1'b1;
        fdata = d;
        step();
        fwr = 1'b0;
    endtask

    task automatic t_sources;
        for (int s = 2; s < 7; s++)
        begin
            wr_flags(7'h00);
            ev = 7'h01 << s;
            step();
            ev = 7'h00;
            step(2);
            chk(flags, 7'h01 << s);
        end
        wr_flags(7'h00);
        wdsel = 1'b1;
        ev = 7'h20;
        step();
        ev = 7'h00;
        wdsel = 1'b0;
        chk(flags, 7'h00);
        $display("sources done");
    endtask

    task automatic t_edges;
        for (int m = 0; m < 4; m++)
        begin
            esel = {2'(m), 2'b00};
            wr_flags(7'h00);
            pin_b = 1'b0;
            step(2);
            chk(flags[1], m[0]);
            wr_flags(7'h00);
            pin_b = 1'b1;
            step(2);
            chk(flags[1], m[1]);
        end
        $display("edges done");
    endtask

    task automatic t_priority;
        esel = 4'h0;
        wr_flags(7'h55);
        chk(flags, 7'h55);
        // Let an edge pass so the write strobe is not raised again at once
        step();
        wr_flags(7'h7f);
        ie_set = 1'b1;
        step();
        ie_set = 1'b0;
        for (int s = 0; s < 7; s++)
        begin
            en = 7'h7f << s;
            step();
            chk({irq, vec}, {1'b1, vt[s]});
        end
        en = 7'h00;
        step();
        chk(irq, 1'b0);
        en = 7'h7f;
        ie_clr = 1'b1;
        step();
        ie_clr = 1'b0;
        chk(irq, 1'b0);
        $display("priority done");
    endtask

    task automatic t_accept;
        esel = 4'h1;
        wr_flags(7'h00);
        pin_a = 1'b0;
        step(2);
        ie_set = 1'b1;
        step();
        ie_set = 1'b0;
        chk({flags, irq, vec}, {7'h01, 1'b1, VEC_EXT_A});
        idone = 1'b1;
        step();
        idone = 1'b0;
        chk({acc, mclr, irq}, 3'b110);
        for (int i = 2; i < 9; i++)
        begin
            step();
            chk({acc, push, pcl, irq}, {1'b1, i < 5, i == 8, 1'b0});
        end
        chk(pcv, VEC_EXT_A);
        chk({stk[23:8], stk[7:0] & 8'hfb}, 24'h123460);
        chk({pcount, status_word[2], flags}, {3'h3, 1'b0, 7'h00});
        step();
        chk(acc, 1'b0);
        $display("accept done");
    endtask

    task automatic t_reset;
        // Pins idle high with both edges armed: no false edge after release
        esel = 4'hf;
        pin_a = 1'b1;
        reset_i = 1'b1;
        step(2);
        chk({pcv, flags, irq}, {VEC_RESET, 7'h00, 1'b0});
        reset_i = 1'b0;
        step(2);
        chk({pcv, flags, irq}, {VEC_RESET, 7'h00, 1'b0});
        $display("reset done");
    endtask

    task automatic give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        step(5);
        reset_i = 1'b0;
        step(2);
        chk({pcv, flags, irq}, {VEC_RESET, 7'h00, 1'b0});
        t_sources();
        t_edges();
        t_priority();
        t_accept();
        t_reset();
        give_verdict();
    end

    initial
    begin
        #100000;
        failures++;
        give_verdict();
    end
endmodule
`default_nettype wire
